/* File: rpot_top.sv */
// Purpose: multi-function open-drain pin output and oscillator digital trim
// Assumes: oscillator and backup indication arrive as pins; register port comes from the serial engine
// Notes:   the pin is only ever pulled low, never driven high
`timescale 1ns/10ps
`include "rpot_map.svh"

// Functional notes
// - alarm mode when alarm on, square wave off
// - alarm output works on backup supply
// - single alarm: pin follows flag, polarity inverts
// - dual alarms, polarity 1: OR of flags
// - dual alarms, polarity 0: NAND of flags
// - all off: pin follows output-level bit
// - general purpose output released on backup
// - normal trim applied once per minute
// - sign 1 adds cycles, 0 removes
// - each magnitude step is two cycles
// - zero magnitude disables trimming
// - coarse trim applied 128 times per second
// - trimming continues on backup supply
// - trim starts automatically after register write
// - weekday write clears flag; never software-set
// - square wave overrides alarm and GPO
// - output-level 1 releases pin, 0 pulls
// - coarse plus square wave gives 64 Hz
module rpot_top
  import rpot_pkg::*;
(
  // clock, reset and enable
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clock_en,
  // asynchronous pins
  input  wire logic        osc_in,
  input  wire logic        on_backup,
  // alarm match pulses from the comparators
  input  wire logic        alarm0_match,
  input  wire logic        alarm1_match,
  // register port from the serial engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // open-drain multi-function pin
  output logic             multi_function_pin_o,
  output logic             multi_function_pin_oe,
  // timebase to the calendar counters
  output logic             second_tick
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0]      clock_control;
  logic [7:0]      oscillator_trim;
  logic            alarm_pin_polarity;
  logic [2:0]      alarm0_match_mask;
  logic [2:0]      alarm1_match_mask;
  logic [2:0]      alarm0_weekday_value;
  logic [2:0]      alarm1_weekday_value;
  logic            alarm0_match_flag;
  logic            alarm1_match_flag;
  logic            osc_meta;
  logic            osc_sync;
  logic            osc_last;
  logic            backup_meta;
  logic            backup_sync;
  logic            osc_tick;
  logic [14:0]     prescaler;
  logic            trim_second;
  logic            adjust_pulse;
  logic            wr_control;
  logic            wr_trim;
  logic            wr_wkday0;
  logic            wr_wkday1;
  logic            square_wave_enable;
  logic            alarm0_enable;
  logic            alarm1_enable;
  logic            coarse_trim_enable;
  logic [1:0]      square_wave_freq_select;
  rpot_pin_mode_e  next_mode;
  rpot_pin_mode_e  pin_mode;
  logic            alarm_level;
  logic            square_level;
  logic            next_level;
  logic            next_pin_oe;
  logic [7:0]      next_rdata;
  localparam logic [7:0] weekday_value_init = `RPOT_WEEKDAY_VALUE_RESET;   // weekday register value after reset

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // two flops per pin; the third oscillator flop only feeds the edge detector
  always_ff @(posedge clock) begin
    if (srst) begin
      osc_meta    <= 1'b0;
      osc_sync    <= 1'b0;
      osc_last    <= 1'b0;
      backup_meta <= 1'b0;
      backup_sync <= 1'b0;
    end else if (clock_en) begin
      osc_meta    <= osc_in;
      osc_sync    <= osc_meta;
      osc_last    <= osc_sync;
      backup_meta <= on_backup;
      backup_sync <= backup_meta;
    end
  end

  // one pulse per rising oscillator edge
  assign osc_tick = osc_sync && !osc_last;

  // ****************************************************************
  // register decode
  // ****************************************************************
  assign wr_control = reg_wr && reg_addr == `RPOT_ADDR_CONTROL;
  assign wr_trim    = reg_wr && reg_addr == `RPOT_ADDR_TRIM;
  assign wr_wkday0  = reg_wr && reg_addr == `RPOT_ADDR_WKDAY0;
  assign wr_wkday1  = reg_wr && reg_addr == `RPOT_ADDR_WKDAY1;

  // control field aliases
  assign square_wave_enable      = clock_control[`RPOT_CTL_SQUARE_WAVE_ENABLE];
  assign alarm0_enable           = clock_control[`RPOT_CTL_A0EN];
  assign alarm1_enable           = clock_control[`RPOT_CTL_A1EN];
  assign coarse_trim_enable      = clock_control[`RPOT_CTL_COARSE];
  assign square_wave_freq_select = clock_control[1:0];

  // control and trim registers; a trim write takes effect at the next instant
  always_ff @(posedge clock) begin
    if (srst) begin
      clock_control   <= `RPOT_CONTROL_RESET;
      oscillator_trim <= `RPOT_TRIM_RESET;
    end else if (clock_en) begin
      if (wr_control) begin
        clock_control <= reg_wdata;
      end
      if (wr_trim) begin
        oscillator_trim <= reg_wdata;
      end
    end
  end

  // alarm weekday/config fields; polarity is shared by both registers
  always_ff @(posedge clock) begin
    if (srst) begin
      alarm_pin_polarity   <= weekday_value_init[`RPOT_WK_POL];
      alarm0_match_mask    <= weekday_value_init[6:4];
      alarm1_match_mask    <= weekday_value_init[6:4];
      alarm0_weekday_value <= weekday_value_init[2:0];
      alarm1_weekday_value <= weekday_value_init[2:0];
    end else if (clock_en) begin
      if (wr_wkday0) begin
        alarm_pin_polarity   <= reg_wdata[`RPOT_WK_POL];
        alarm0_match_mask    <= reg_wdata[6:4];
        alarm0_weekday_value <= reg_wdata[2:0];
      end else if (wr_wkday1) begin
        alarm_pin_polarity   <= reg_wdata[`RPOT_WK_POL];
        alarm1_match_mask    <= reg_wdata[6:4];
        alarm1_weekday_value <= reg_wdata[2:0];
      end
    end
  end

  // ****************************************************************
  // alarm match flags
  // ****************************************************************
  // a weekday write clears only its own alarm's flag; a match in the same cycle wins
  always_ff @(posedge clock) begin
    if (srst) begin
      alarm0_match_flag <= 1'b0;
      alarm1_match_flag <= 1'b0;
    end else if (clock_en) begin
      if (alarm0_match) begin
        alarm0_match_flag <= 1'b1;
      end else if (wr_wkday0) begin
        alarm0_match_flag <= 1'b0;
      end
      if (alarm1_match) begin
        alarm1_match_flag <= 1'b1;
      end else if (wr_wkday1) begin
        alarm1_match_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  always_comb begin
    case (reg_addr)
      `RPOT_ADDR_CONTROL: next_rdata = clock_control;
      `RPOT_ADDR_TRIM:    next_rdata = oscillator_trim;
      `RPOT_ADDR_WKDAY0:  next_rdata = {alarm_pin_polarity, alarm0_match_mask, alarm0_match_flag, alarm0_weekday_value};
      `RPOT_ADDR_WKDAY1:  next_rdata = {alarm_pin_polarity, alarm1_match_mask, alarm1_match_flag, alarm1_weekday_value};
      default:            next_rdata = `RPOT_READ_UNMAPPED;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= `RPOT_READ_UNMAPPED;
    end else if (clock_en && reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // trimmed timebase
  // ****************************************************************
  rpot_trim u_trim (
    .clock              (clock),
    .srst               (srst),
    .clock_en           (clock_en),
    .osc_tick           (osc_tick),
    .trim_sign          (oscillator_trim[`RPOT_TRIM_SIGN]),
    .trim_magnitude     (oscillator_trim[6:0]),
    .coarse_trim_enable (coarse_trim_enable),
    .prescaler          (prescaler),
    .second_tick        (trim_second),
    .adjust_pulse       (adjust_pulse)
  );

  // second pulse re-timed for the calendar counters
  always_ff @(posedge clock) begin
    if (srst) begin
      second_tick <= 1'b0;
    end else if (clock_en) begin
      second_tick <= trim_second;
    end
  end

  // ****************************************************************
  // pin mode and level
  // ****************************************************************
  always_comb begin
    if (square_wave_enable) begin
      next_mode = backup_sync ? RPOT_PIN_RELEASE : RPOT_PIN_SQW;
    end else if (alarm0_enable || alarm1_enable) begin
      next_mode = RPOT_PIN_ALARM;
    end else begin
      next_mode = backup_sync ? RPOT_PIN_RELEASE : RPOT_PIN_GPO;
    end
  end

  // alarm combination by enables and polarity
  always_comb begin
    if (alarm0_enable && alarm1_enable) begin
      if (alarm_pin_polarity) begin
        alarm_level = alarm0_match_flag || alarm1_match_flag;
      end else begin
        alarm_level = !(alarm0_match_flag && alarm1_match_flag);
      end
    end else if (alarm0_enable) begin
      alarm_level = alarm_pin_polarity ? alarm0_match_flag : !alarm0_match_flag;
    end else begin
      alarm_level = alarm_pin_polarity ? alarm1_match_flag : !alarm1_match_flag;
    end
  end

  // square wave taps; the raw oscillator rate escapes trimming
  always_comb begin
    if (coarse_trim_enable) begin
      square_level = prescaler[`RPOT_TAP_64HZ];
    end else begin
      case (square_wave_freq_select)
        `RPOT_SQW_1HZ: square_level = prescaler[`RPOT_TAP_1HZ];
        `RPOT_SQW_4K:  square_level = prescaler[`RPOT_TAP_4K];
        `RPOT_SQW_8K:  square_level = prescaler[`RPOT_TAP_8K];
        default:       square_level = osc_sync;
      endcase
    end
  end

  // open drain: enable pulls low, released otherwise
  always_comb begin
    case (next_mode)
      RPOT_PIN_GPO:   next_level = clock_control[`RPOT_CTL_OUT];
      RPOT_PIN_ALARM: next_level = alarm_level;
      RPOT_PIN_SQW:   next_level = square_level;
      default:        next_level = 1'b1;
    endcase
    next_pin_oe = !next_level;
  end

  // registered pin drive
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_mode              <= RPOT_PIN_RELEASE;
      multi_function_pin_o  <= 1'b0;
      multi_function_pin_oe <= 1'b0;
    end else if (clock_en) begin
      pin_mode              <= next_mode;
      multi_function_pin_o  <= 1'b0;
      multi_function_pin_oe <= next_pin_oe;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_flag_write_clear: assert property (@(posedge clock) disable iff (srst)
    (clock_en && wr_wkday0 && !alarm0_match) |=> !alarm0_match_flag)
    else $error("weekday write did not clear alarm 0 flag");
  a_flag_set_wins: assert property (@(posedge clock) disable iff (srst)
    (clock_en && alarm1_match) |=> alarm1_match_flag ##1 (alarm1_match_flag || $past(wr_wkday1)))
    else $error("alarm 1 match lost");
  a_single_alarm_pin: assert property (@(posedge clock) disable iff (srst)
    (clock_en && !square_wave_enable && alarm0_enable && !alarm1_enable)
      |=> multi_function_pin_oe == ($past(alarm_pin_polarity) ^ $past(alarm0_match_flag)))
    else $error("single alarm pin level wrong");
  a_dual_or_pin: assert property (@(posedge clock) disable iff (srst)
    (clock_en && !square_wave_enable && alarm0_enable && alarm1_enable && alarm_pin_polarity)
      |=> multi_function_pin_oe == !($past(alarm0_match_flag) || $past(alarm1_match_flag)))
    else $error("dual alarm OR level wrong");
  a_dual_nand_pin: assert property (@(posedge clock) disable iff (srst)
    (clock_en && !square_wave_enable && alarm0_enable && alarm1_enable && !alarm_pin_polarity)
      |=> multi_function_pin_oe == ($past(alarm0_match_flag) && $past(alarm1_match_flag)))
    else $error("dual alarm NAND level wrong");
  a_gpo_level_pin: assert property (@(posedge clock) disable iff (srst)
    (clock_en && clock_control[7:4] == 4'h0 && !backup_sync) |=> multi_function_pin_oe)
    else $error("output-level low did not pull the pin");
  a_gpo_backup_off: assert property (@(posedge clock) disable iff (srst)
    (clock_en && !square_wave_enable && !alarm0_enable && !alarm1_enable && backup_sync)
      |=> !multi_function_pin_oe && pin_mode == RPOT_PIN_RELEASE)
    else $error("general purpose output active on backup");
  a_sqw_override: assert property (@(posedge clock) disable iff (srst)
    (clock_en && square_wave_enable && !backup_sync) |=> pin_mode == RPOT_PIN_SQW)
    else $error("square wave did not own the pin");
  a_alarm_on_backup: assert property (@(posedge clock) disable iff (srst)
    (clock_en && !square_wave_enable && (alarm0_enable || alarm1_enable) && backup_sync)
      |=> pin_mode == RPOT_PIN_ALARM)
    else $error("alarm output lost on backup");
  a_coarse_64hz: assert property (@(posedge clock) disable iff (srst)
    (clock_en && square_wave_enable && coarse_trim_enable && !backup_sync)
      |=> multi_function_pin_oe == !$past(prescaler[`RPOT_TAP_64HZ]))
    else $error("coarse square wave not on 64 Hz tap");

  c_dual_alarm_low: cover property (@(posedge clock) disable iff (srst)
    pin_mode == RPOT_PIN_ALARM && alarm0_enable && alarm1_enable && multi_function_pin_oe);
  c_gpo_low: cover property (@(posedge clock) disable iff (srst)
    pin_mode == RPOT_PIN_GPO && multi_function_pin_oe);
  c_sqw_toggle: cover property (@(posedge clock) disable iff (srst)
    pin_mode == RPOT_PIN_SQW && multi_function_pin_oe ##1 !multi_function_pin_oe);
  c_trim_applied: cover property (@(posedge clock) disable iff (srst)
    adjust_pulse);

endmodule

/* File: rpot_map.svh */
// Purpose: register offsets, field positions, reset values and counts of the pin output and trim block
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef RPOT_MAP_SVH
`define RPOT_MAP_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define RPOT_ADDR_CONTROL     8'h07
`define RPOT_ADDR_TRIM        8'h08
`define RPOT_ADDR_WKDAY0      8'h0d
`define RPOT_ADDR_WKDAY1      8'h14

// ****************************************************************
// reset values
// ****************************************************************
`define RPOT_CONTROL_RESET    8'h80
`define RPOT_TRIM_RESET       8'h00
`define RPOT_WEEKDAY_VALUE_RESET      8'h00
`define RPOT_READ_UNMAPPED    8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define RPOT_CTL_OUT          7
`define RPOT_CTL_SQUARE_WAVE_ENABLE        6
`define RPOT_CTL_A1EN         5
`define RPOT_CTL_A0EN         4
`define RPOT_CTL_COARSE       2
`define RPOT_WK_POL           7
`define RPOT_WK_FLAG          3
`define RPOT_TRIM_SIGN        7

// ****************************************************************
// square wave select codes and prescaler taps
// ****************************************************************
`define RPOT_SQW_1HZ          2'h0
`define RPOT_SQW_4K           2'h1
`define RPOT_SQW_8K           2'h2
`define RPOT_SQW_32K          2'h3
`define RPOT_TAP_1HZ          14
`define RPOT_TAP_4K           2
`define RPOT_TAP_8K           1
`define RPOT_TAP_64HZ         8

// ****************************************************************
// oscillator counts
// ****************************************************************
`define RPOT_PRESC_LAST       15'h7fff
`define RPOT_COARSE_LAST      8'hff
`define RPOT_SEC_LAST         6'h3b

`endif

/* File: rpot_pkg.sv */
// Purpose: types shared by the pin output and trim block
// Assumes: nothing
// Notes:   one-hot state codes
package rpot_pkg;

  // ****************************************************************
  // pin output modes
  // ****************************************************************
  typedef enum logic [3:0] {
    RPOT_PIN_GPO     = 4'b0001,
    RPOT_PIN_ALARM   = 4'b0010,
    RPOT_PIN_SQW     = 4'b0100,
    RPOT_PIN_RELEASE = 4'b1000
  } rpot_pin_mode_e;

  // ****************************************************************
  // trim engine states
  // ****************************************************************
  typedef enum logic [1:0] {
    RPOT_TRIM_COUNT = 2'b01,
    RPOT_TRIM_HOLD  = 2'b10
  } rpot_trim_state_e;

endpackage

/* File: rpot_trim.sv */
// Purpose: oscillator prescaler with periodic digital trim
// Assumes: osc_tick is a one-cycle pulse per oscillator cycle
// Notes:   adding advances the prescaler, removing holds it
`timescale 1ns/10ps
`include "rpot_map.svh"

module rpot_trim
  import rpot_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        clock_en,
  // oscillator and trim settings
  input  wire logic        osc_tick,
  input  wire logic        trim_sign,
  input  wire logic [6:0]  trim_magnitude,
  input  wire logic        coarse_trim_enable,
  // timebase
  output logic      [14:0] prescaler,
  output logic             second_tick,
  output logic             adjust_pulse
);

  rpot_trim_state_e state;
  logic [5:0]       sec_cnt;
  logic [7:0]       hold_cnt;
  logic [7:0]       step;
  logic             adjust_now;
  logic [15:0]      next_sum;

  // ****************************************************************
  // adjustment instant and next prescaler value
  // ****************************************************************
  always_comb begin
    step       = {trim_magnitude, 1'b0};
    adjust_now = 1'b0;
    if (osc_tick && state == RPOT_TRIM_COUNT && trim_magnitude != 7'h00) begin
      if (coarse_trim_enable) begin
        adjust_now = (prescaler[7:0] == `RPOT_COARSE_LAST);
      end else begin
        adjust_now = (prescaler == `RPOT_PRESC_LAST) && (sec_cnt == `RPOT_SEC_LAST);
      end
    end
    next_sum = {1'b0, prescaler} + 16'h0001 + ((adjust_now && trim_sign) ? {8'h00, step} : 16'h0000);
  end

  // prescaler, hold count and state
  always_ff @(posedge clock) begin
    if (srst) begin
      state     <= RPOT_TRIM_COUNT;
      prescaler <= 15'h0000;
      hold_cnt  <= 8'h00;
    end else if (clock_en && osc_tick) begin
      case (state)
        RPOT_TRIM_COUNT: begin
          prescaler <= next_sum[14:0];
          if (adjust_now && !trim_sign) begin
            hold_cnt <= step;
            state    <= RPOT_TRIM_HOLD;
          end
        end
        RPOT_TRIM_HOLD: begin
          hold_cnt <= hold_cnt - 8'h01;
          if (hold_cnt == 8'h01) begin
            state <= RPOT_TRIM_COUNT;
          end
        end
        default: begin
          state <= RPOT_TRIM_COUNT;
        end
      endcase
    end
  end

  // seconds within the minute and one-cycle pulses
  always_ff @(posedge clock) begin
    if (srst) begin
      sec_cnt      <= 6'h00;
      second_tick  <= 1'b0;
      adjust_pulse <= 1'b0;
    end else if (clock_en) begin
      second_tick  <= osc_tick && state == RPOT_TRIM_COUNT && next_sum[15];
      adjust_pulse <= adjust_now;
      if (osc_tick && state == RPOT_TRIM_COUNT && next_sum[15]) begin
        sec_cnt <= (sec_cnt == `RPOT_SEC_LAST) ? 6'h00 : sec_cnt + 6'h01;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_trim_off_plain: assert property (@(posedge clock) disable iff (srst)
    (clock_en && osc_tick && state == RPOT_TRIM_COUNT && trim_magnitude == 7'h00)
      |=> prescaler == 15'($past(prescaler) + 15'h0001))
    else $error("zero trim changed the prescaler step");
  a_trim_add_jump: assert property (@(posedge clock) disable iff (srst)
    (clock_en && adjust_now && trim_sign)
      |=> prescaler == 15'($past(prescaler) + 15'h0001 + {7'h00, $past(step)}))
    else $error("positive trim did not advance the prescaler");
  a_trim_sub_hold: assert property (@(posedge clock) disable iff (srst)
    (clock_en && adjust_now && !trim_sign)
      |=> state == RPOT_TRIM_HOLD && hold_cnt == $past(step))
    else $error("negative trim did not start the hold");
  c_trim_hold_end: cover property (@(posedge clock) disable iff (srst)
    state == RPOT_TRIM_HOLD ##1 state == RPOT_TRIM_COUNT);

endmodule

/* File: rpot_board.sv */
// Purpose: far side model: oscillator source and pull-up on the open-drain pin
// Assumes: bench clock of 100 MHz
// Notes:   oscillator sped up to six bench cycles so trim periods stay short
`timescale 1ns/10ps
module rpot_board (
  // bench clock
  input  wire logic clock,
  // pull-down enable from the device
  input  wire logic pin_oe,
  // oscillator, pin level and oscillator edge count
  output logic      osc_in,
  output logic      pin_level,
  output int        ticks
);
  logic [1:0] div = 2'h0;
  logic       osc = 1'b0;
  int         cnt = 0;

  // oscillator toggles every third cycle, rising edges counted
  always @(posedge clock) begin
    div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
    if (div == 2'h2) begin
      osc <= ~osc;
      cnt <= cnt + (osc ? 0 : 1);
    end
  end

  // pull-up wins whenever the device lets go of the pin
  assign pin_level = ~pin_oe;
  assign osc_in    = osc;
  assign ticks     = cnt;
endmodule

/* File: test_rpot_top.sv */
// Purpose: register, pin mode and trim checks of the pin output and trim block
// Assumes: pin level comes from the board pull-up model
// Notes:   trim is observed as the half period of the coarse square wave
`timescale 1ns/10ps
module test_rpot_top;
  import rpot_pkg::*;
  logic       clock = 1'b0;
  logic       srst = 1'b1;
  logic       on_backup = 1'b0;
  logic       a0 = 1'b0;
  logic       a1 = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       pin_oe;
  logic       pin_level;
  logic       pin_o;
  logic       sec_o;
  logic       osc_in;
  int         ticks;
  int         err_count = 0;
  int         tests_run = 0;
  int         t1;
  int         t2;
  logic [7:0] trims [5] = '{8'h80, 8'h83, 8'h03, 8'hff, 8'h7f};
  int         halfs [5] = '{256, 250, 262, 2, 510};

  rpot_top dut_u (.clock(clock), .srst(srst), .clock_en(1'b1), .osc_in(osc_in), .on_backup(on_backup),
    .alarm0_match(a0), .alarm1_match(a1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .multi_function_pin_o(pin_o), .multi_function_pin_oe(pin_oe),
    .second_tick(sec_o));
  rpot_board board_u (.clock(clock), .pin_oe(pin_oe), .osc_in(osc_in), .pin_level(pin_level), .ticks(ticks));

  // clock of 10 ns
  always #5 clock = ~clock;

  task automatic stop_test;
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk({2'b00, reg_rdata}, {2'b00, exp});
  endtask

  task automatic pin(input logic exp);
    repeat (6) @(posedge clock);
    chk({9'h000, pin_level}, {9'h000, exp});
    chk({9'h000, pin_o}, 10'h000);
  endtask

  // ticks counted up to the next trimmed second pulse
  task automatic sec_at(output int t);
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (sec_o !== 1'b1 && k < 4000);
    t = ticks;
  endtask

  // ticks counted up to the next change of the pin level
  task automatic edge_at(output int t);
    logic lv;
    int   k;
    lv = pin_level;
    k = 0;
    while (pin_level === lv && k < 4000) begin
      @(posedge clock);
      k++;
    end
    t = ticks;
  endtask

  task automatic half(input int exp);
    edge_at(t1);
    edge_at(t1);
    edge_at(t2);
    chk(10'(t2 - t1), 10'(exp));
  endtask

  // watchdog
  initial begin
    #900000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rd(8'h07, 8'h80);
    rd(8'h08, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h08, 8'h5a);
    rd(8'h08, 8'h5a);
    // every alarm enable, polarity and flag combination
    for (int e = 1; e < 4; e++)
      for (int p = 0; p < 2; p++)
        for (int f = 0; f < 4; f++) begin
          wr(8'h07, {2'b00, 2'(e), 4'h0});
          wr(8'h0d, {p[0], 7'h00});
          wr(8'h14, {p[0], 7'h00});
          a0 <= f[0];
          a1 <= f[1];
          @(posedge clock);
          a0 <= 1'b0;
          a1 <= 1'b0;
          pin((e == 3) ? (p[0] ? |f[1:0] : ~&f[1:0]) : ((e == 1 ? f[0] : f[1]) ~^ p[0]));
        end
    rd(8'h0d, 8'h88);
    wr(8'h0d, 8'h08);
    rd(8'h0d, 8'h00);
    pin(1'b1);
    on_backup <= 1'b1;
    a0 <= 1'b1;
    @(posedge clock);
    a0 <= 1'b0;
    pin(1'b0);
    wr(8'h07, 8'h00);
    pin(1'b1);
    on_backup <= 1'b0;
    pin(1'b0);
    wr(8'h07, 8'h80);
    pin(1'b1);
    // zero trim, coarse square wave, then load each trim
    wr(8'h08, 8'h00);
    wr(8'h07, 8'h44);
    half(256);
    for (int i = 0; i < 5; i++) begin
      wr(8'h08, trims[i]);
      half(halfs[i]);
    end
    // largest add in coarse mode: one trimmed second every 256 ticks
    wr(8'h08, 8'hff);
    sec_at(t1);
    sec_at(t1);
    sec_at(t2);
    chk(10'(t2 - t1), 10'h100);
    wr(8'h08, 8'h80);
    wr(8'h07, 8'h74);
    half(256);
    // untrimmed 4.096 kHz and 8.192 kHz taps, alarms still enabled
    wr(8'h07, 8'h71);
    half(4);
    wr(8'h07, 8'h72);
    half(2);
    stop_test();
  end
endmodule
